// ===== verilog/ssm_pkg.sv
// package: constants for the safing spi monitor
package ssm_pkg;
  localparam int FRAME_BITS = 16;
  localparam logic [3:0] SEQ_RELOAD = 4'hF;
  localparam logic [3:0] SEQ_FROZEN = 4'hE;
  localparam logic [3:0] VALID_CLEAR = 4'h0;
  localparam logic [1:0] RESP_TYPE_DATA = 2'h1;
  // frame layout: [15:14] response type, [13:11] seq id, [9:0] sample
  localparam int RESP_TYPE_MSB = 15;
  localparam int RESP_TYPE_LSB = 14;
  localparam int SEQ_ID_MSB = 13;
  localparam int SEQ_ID_LSB = 11;
  localparam int SAMPLE_MSB = 9;
  localparam int SAMPLE_LSB = 0;
  localparam logic [3:0] SEQ_NARROW_FROM = 4'h3;
  localparam logic signed [9:0] SAMPLE_LO_NARROW = -10'sd480;
  localparam logic signed [9:0] SAMPLE_HI_NARROW = 10'sd480;
  localparam logic [7:0] UNLOCK_XOR = 8'hAD;
  localparam logic [7:0] THR_DEFAULT_0 = 8'h0D;
  localparam logic [7:0] THR_DEFAULT_1 = 8'h95;
  localparam logic [7:0] THR_DEFAULT_2_5 = 8'h08;
  localparam logic [7:0] THR_DEFAULT_6_7 = 8'h04;
  localparam int THR_COUNT = 8;
  localparam int DWELL_SHORT_MS = 255;
  localparam int DWELL_LONG_MS = 2000;
  // safing state machine modes as seen by this block
  typedef enum logic [2:0] {
    SSM_STARTUP = 3'h0,
    SSM_DIAG = 3'h1,
    SSM_SAFING = 3'h3,
    SSM_SCRAP = 3'h2,
    SSM_ARMING = 3'h6
  } ssm_mode_t;
  // command kinds seen on the command port
  typedef enum logic [1:0] {
    SSM_CMD_OTHER = 2'h0,
    SSM_CMD_UNLOCK = 2'h1,
    SSM_CMD_THR_WRITE = 2'h2
  } ssm_cmd_t;
endpackage : ssm_pkg

// ===== verilog/ssm_thr_mem.sv
// threshold store: eight bytes, registered read ports, protected writes
`timescale 1ns/100ps
`default_nettype none
module ssm_thr_mem (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rd_data,
  input wire logic [2:0] cmp_idx,
  output logic [7:0] cmp_data
);
  typedef struct packed {
    logic [7:0][7:0] thr;
    logic [7:0] rd;
    logic [7:0] cmp;
  } ssm_mem_state_t;

  ssm_mem_state_t st_ff;
  ssm_mem_state_t nxt_st;

  // default encoding per slot
  function automatic logic [7:0] thr_default(input int k);
    if (k == 0) begin
      return ssm_pkg::THR_DEFAULT_0;
    end else if (k == 1) begin
      return ssm_pkg::THR_DEFAULT_1;
    end else if (k < 6) begin
      return ssm_pkg::THR_DEFAULT_2_5;
    end
    return ssm_pkg::THR_DEFAULT_6_7;
  endfunction : thr_default

  // one write port; reads come from registers to keep timing clean
  always_comb begin
    nxt_st = st_ff;
    if (wr_en) begin
      nxt_st.thr[wr_idx] = wr_data;
    end
    nxt_st.rd = st_ff.thr[rd_idx];
    nxt_st.cmp = st_ff.thr[cmp_idx];
  end

  // defaults on safing reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < ssm_pkg::THR_COUNT; k++) begin
        st_ff.thr[k] <= thr_default(k); // R18
      end
      st_ff.rd <= 8'h00;
      st_ff.cmp <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd;
  assign cmp_data = st_ff.cmp;
endmodule : ssm_thr_mem
`default_nettype wire

// ===== verilog/ssm_monitor.sv
// safing spi monitor: frame check, sequence and data validation, thresholds
// Operation
// R1 - capture first 16 so bits while selected
// R2 - frame valid on release after 16 edges
// R3 - overlapping chip selects spoil the frame
// R4 - message flag only when counter not frozen
// R5 - compare seq id with expected count
// R6 - mismatch sets fault, blocks rest of period
// R7 - host keeps full sampling order each period
// R8 - data ok needs type 01, message, no fault
// R9 - sample range depends on sequence count
// R10 - data ok only in safing mode
// R11 - sync loads 1111, messages advance counter
// R12 - sequence counter never passes 1110
// R13 - sequence counter not serially accessible
// R14 - valid counter clears on sync, freezes
// R15 - valid count returned on safety control
// R16 - eight thresholds, top bit picks dwell
// R17 - threshold k serves sequence 2k, 2k+1
// R18 - thresholds load defaults on reset
// R19 - threshold writes only in start-up mode
// R20 - threshold write needs unlock directly before
// R21 - write data must equal unlock xor ad
// R22 - eight separate threshold access commands
// R23 - comparison operand is zero plus threshold
// R24 - responses inspected only in safing mode
// R25 - top bit one selects long dwell
// R26 - any other command cancels pending unlock
`timescale 1ns/100ps
`default_nettype none
module ssm_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  // snooped spi link, all asynchronous pins
  input wire logic spi_sck,
  input wire logic spi_so,
  input wire logic [3:0] spi_cs_n,
  // sample period sync pin
  input wire logic sat_sync,
  // safing state machine mode
  input wire ssm_pkg::ssm_mode_t ssm_mode,
  // decoded command port from the device's spi slave
  input wire logic cmd_valid,
  input wire ssm_pkg::ssm_cmd_t cmd_kind,
  input wire logic [2:0] cmd_thr_idx,
  input wire logic [7:0] cmd_data,
  output logic thr_write_done,
  output logic thr_write_rejected,
  // threshold read back through the access commands
  input wire logic [2:0] thr_rd_idx,
  output logic [7:0] thr_rd_data,
  // status toward the safety control command
  output logic seq_fault_flag,
  output logic [3:0] valid_count,
  // pulses and operands toward the comparison logic
  output logic sensor_message_ok,
  output logic sequence_mismatch,
  output logic sample_data_ok,
  output logic sample_data_ok_sig,
  output logic [3:0] cmp_seq,
  output logic [9:0] cmp_sample,
  output logic [8:0] cmp_threshold,
  output logic cmp_dwell_long,
  output logic cmp_enable
);
  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] sync_s;
    logic [3:0][2:0] cs_s;
    logic so_s1;
    logic so_s2;
    logic so_s3;
    logic sck_q;
    logic sync_q;
    logic [3:0] cs_q;
    logic in_frame;
    logic multi_cs;
    logic [4:0] edge_cnt;
    logic [15:0] shift;
    logic [3:0] seq_cnt;
    logic [3:0] valid_cnt;
    logic fault;
    logic msg;
    logic mism;
    logic dok;
    logic [15:0] frame;
    logic unlocked;
    logic [7:0] unlock_data;
    logic wr_done;
    logic wr_rej;
    logic cmp_en;
  } ssm_mon_state_t;

  ssm_mon_state_t st_ff;
  ssm_mon_state_t nxt_st;
  logic thr_wr_en;
  logic [7:0] thr_cmp;

  // two-stage agreement: the last two of the three stages must match before a change counts
  function automatic logic settled(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction : settled

  // signed range check on the sample, narrow window once count passes 2
  function automatic logic sample_in_range(input logic [9:0] v, input logic [3:0] seq);
    logic signed [9:0] sv;
    sv = $signed(v);
    if (seq >= ssm_pkg::SEQ_NARROW_FROM) begin
      return (sv >= ssm_pkg::SAMPLE_LO_NARROW) && (sv <= ssm_pkg::SAMPLE_HI_NARROW); // R9
    end
    return 1'b1; // full 10-bit span is -512..+511 R9
  endfunction : sample_in_range

  logic sck_now;
  logic sync_now;
  logic [3:0] cs_act;
  logic any_cs;
  logic sck_rise;
  logic sync_rise;
  logic frame_end;
  logic frame_good;
  logic [15:0] cap;
  logic [3:0] seq_next;
  logic cnt_not_frozen;
  logic id_match;
  logic mism_now;
  logic dok_now;
  logic unlock_ok;
  logic [2:0] one_hot_cnt;
  logic [3:0] cs_lvl;
  logic msg_take;

  // pin conditioning and edge detection
  always_comb begin
    sck_now = settled(st_ff.sck_s, st_ff.sck_q);
    sync_now = settled(st_ff.sync_s, st_ff.sync_q);
    for (int i = 0; i < 4; i++) begin
      // hold the last agreed level so a half-synced select cannot end a frame
      cs_lvl[i] = settled(st_ff.cs_s[i], st_ff.cs_q[i]);
      cs_act[i] = ~cs_lvl[i];
    end
    one_hot_cnt = 3'(cs_act[0]) + 3'(cs_act[1]) + 3'(cs_act[2]) + 3'(cs_act[3]);
    any_cs = |cs_act;
    sck_rise = sck_now & ~st_ff.sck_q;
    sync_rise = sync_now & ~st_ff.sync_q;
  end

  // frame qualification and response decode
  always_comb begin
    frame_end = st_ff.in_frame & ~any_cs;
    frame_good = frame_end & (st_ff.edge_cnt >= 5'(ssm_pkg::FRAME_BITS)) & ~st_ff.multi_cs; // R2 R3
    cap = st_ff.shift;
    cnt_not_frozen = (st_ff.seq_cnt != ssm_pkg::SEQ_FROZEN); // R4 R12
    seq_next = st_ff.seq_cnt + 4'h1;
    // counter shown to the comparison is the one this message takes
    id_match = (cap[ssm_pkg::SEQ_ID_MSB:ssm_pkg::SEQ_ID_LSB] == seq_next[2:0]); // R5
    mism_now = 1'b0;
    dok_now = 1'b0;
    msg_take = frame_good && cnt_not_frozen && ssm_mode == ssm_pkg::SSM_SAFING; // R4 R24
    if (msg_take) begin
      mism_now = ~id_match; // R5
      dok_now = (cap[ssm_pkg::RESP_TYPE_MSB:ssm_pkg::RESP_TYPE_LSB] == ssm_pkg::RESP_TYPE_DATA)
        && !(st_ff.fault || mism_now)
        && sample_in_range(cap[ssm_pkg::SAMPLE_MSB:ssm_pkg::SAMPLE_LSB], seq_next); // R8 R10
    end
  end

  // unlock check on a threshold write
  always_comb begin
    unlock_ok = st_ff.unlocked && (cmd_data == (st_ff.unlock_data ^ ssm_pkg::UNLOCK_XOR)); // R20 R21
    thr_wr_en = cmd_valid && cmd_kind == ssm_pkg::SSM_CMD_THR_WRITE && unlock_ok
      && ssm_mode == ssm_pkg::SSM_STARTUP; // R19
  end

  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sck_s = {st_ff.sck_s[1:0], spi_sck};
    nxt_st.sync_s = {st_ff.sync_s[1:0], sat_sync};
    for (int i = 0; i < 4; i++) begin
      nxt_st.cs_s[i] = {st_ff.cs_s[i][1:0], spi_cs_n[i]};
    end
    nxt_st.so_s1 = spi_so;
    nxt_st.so_s2 = st_ff.so_s1;
    nxt_st.so_s3 = st_ff.so_s2;
    nxt_st.sck_q = sck_now;
    nxt_st.sync_q = sync_now;
    nxt_st.cs_q = cs_lvl;
    nxt_st.msg = 1'b0;
    nxt_st.mism = 1'b0;
    nxt_st.dok = 1'b0;
    nxt_st.cmp_en = 1'b0;
    nxt_st.wr_done = 1'b0;
    nxt_st.wr_rej = 1'b0;
    // frame tracking; so sampled on the same delay as sck
    if (any_cs) begin
      nxt_st.in_frame = 1'b1;
      if (!st_ff.in_frame) begin
        nxt_st.edge_cnt = 5'h00;
        nxt_st.multi_cs = 1'b0;
      end
      if (one_hot_cnt > 3'h1) begin
        nxt_st.multi_cs = 1'b1; // R3
      end
      if (sck_rise && st_ff.in_frame) begin
        if (st_ff.edge_cnt < 5'(ssm_pkg::FRAME_BITS)) begin
          nxt_st.shift = {st_ff.shift[14:0], st_ff.so_s3}; // R1
          nxt_st.edge_cnt = st_ff.edge_cnt + 5'h01;
        end
      end
    end else begin
      nxt_st.in_frame = 1'b0;
    end
    // qualified message: counters, fault and pulses
    if (msg_take) begin // R4 R24
      nxt_st.msg = 1'b1;
      nxt_st.seq_cnt = seq_next; // R11
      nxt_st.mism = mism_now;
      nxt_st.frame = cap;
      if (mism_now) begin
        nxt_st.fault = 1'b1; // R6
      end
      if (dok_now) begin
        nxt_st.dok = 1'b1;
        nxt_st.valid_cnt = st_ff.valid_cnt + 4'h1; // R14
      end
      nxt_st.cmp_en = dok_now; // R6
    end
    // sync edge restarts the period; a mismatch on that very edge is kept, the safe side
    if (sync_rise) begin
      nxt_st.seq_cnt = ssm_pkg::SEQ_RELOAD; // R11
      nxt_st.valid_cnt = ssm_pkg::VALID_CLEAR; // R14
      nxt_st.fault = msg_take && mism_now; // R6
      nxt_st.cmp_en = 1'b0;
    end
    // any command clears a pending unlock unless it is a fresh unlock
    if (cmd_valid) begin
      nxt_st.unlocked = (cmd_kind == ssm_pkg::SSM_CMD_UNLOCK); // R20 R26
      if (cmd_kind == ssm_pkg::SSM_CMD_UNLOCK) begin
        nxt_st.unlock_data = cmd_data;
      end
      nxt_st.wr_done = thr_wr_en;
      nxt_st.wr_rej = (cmd_kind == ssm_pkg::SSM_CMD_THR_WRITE) && !thr_wr_en;
    end
  end

  // register the whole state; chip selects idle high under reset, other pins low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.sck_s <= 3'h0;
      st_ff.cs_s <= '1;
      st_ff.cs_q <= '1;
      st_ff.seq_cnt <= ssm_pkg::SEQ_RELOAD;
      st_ff.valid_cnt <= ssm_pkg::VALID_CLEAR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // threshold store; index is the message's sequence number halved
  ssm_thr_mem u_thr (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_en(thr_wr_en), // R22
    .wr_idx(cmd_thr_idx),
    .wr_data(cmd_data),
    .rd_idx(thr_rd_idx),
    .rd_data(thr_rd_data),
    .cmp_idx(seq_next[3:1]), // R17
    .cmp_data(thr_cmp)
  );

  // outputs; seq counter itself has no write path and is not exposed serially R13
  assign sensor_message_ok = st_ff.msg;
  assign sequence_mismatch = st_ff.mism;
  assign sample_data_ok = st_ff.dok;
  assign sample_data_ok_sig = st_ff.dok;
  assign seq_fault_flag = st_ff.fault;
  assign valid_count = st_ff.valid_cnt; // R15
  assign cmp_seq = st_ff.seq_cnt;
  assign cmp_sample = st_ff.frame[ssm_pkg::SAMPLE_MSB:ssm_pkg::SAMPLE_LSB];
  assign cmp_threshold = {1'b0, thr_cmp}; // R23
  assign cmp_dwell_long = thr_cmp[7]; // R16 R25
  assign cmp_enable = st_ff.cmp_en;
  assign thr_write_done = st_ff.wr_done;
  assign thr_write_rejected = st_ff.wr_rej;
endmodule : ssm_monitor
`default_nettype wire

// ===== bench/ssm_monitor_chk.sv
// checker: port-level assertions for the safing spi monitor
`timescale 1ns/100ps
`default_nettype none
module ssm_monitor_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire ssm_pkg::ssm_mode_t ssm_mode,
  input wire logic cmd_valid,
  input wire ssm_pkg::ssm_cmd_t cmd_kind,
  input wire logic thr_write_done,
  input wire logic thr_write_rejected,
  input wire logic seq_fault_flag,
  input wire logic [3:0] valid_count,
  input wire logic sensor_message_ok,
  input wire logic sequence_mismatch,
  input wire logic sample_data_ok,
  input wire logic [3:0] cmp_seq,
  input wire logic [8:0] cmp_threshold,
  input wire logic cmp_dwell_long
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // message pulses and what rides with them
  msg_mode_a: assert property (sensor_message_ok |-> ssm_mode == ssm_pkg::SSM_SAFING)
    else $error("message outside safing");
  data_ok_cause_a: assert property (sample_data_ok |-> sensor_message_ok && !sequence_mismatch)
    else $error("data ok without clean message");
  mism_on_msg_a: assert property (sequence_mismatch |-> sensor_message_ok)
    else $error("mismatch without message");
  fault_set_a: assert property (sequence_mismatch |=> seq_fault_flag)
    else $error("fault flag not set");
  seq_range_a: assert property (sensor_message_ok |-> cmp_seq != 4'hF)
    else $error("sequence count passed frozen value");
  operand_a: assert property (sensor_message_ok |-> !cmp_threshold[8] && cmp_dwell_long == cmp_threshold[7])
    else $error("threshold operand malformed");
  // valid counter only steps by one or clears
  valid_step_a: assert property ($changed(valid_count) |->
    valid_count == $past(valid_count) + 4'h1 || valid_count == 4'h0)
    else $error("valid count jumped");
  // every write command gets exactly one answer
  thr_answer_a: assert property (cmd_valid && cmd_kind == ssm_pkg::SSM_CMD_THR_WRITE |=>
    thr_write_done ^ thr_write_rejected)
    else $error("write command unanswered");
  done_cause_a: assert property (thr_write_done |-> $past(ssm_mode) == ssm_pkg::SSM_STARTUP)
    else $error("write accepted outside start-up");
endmodule : ssm_monitor_chk
bind ssm_monitor ssm_monitor_chk chk (.sys_clk, .reset, .ssm_mode, .cmd_valid, .cmd_kind,
  .thr_write_done, .thr_write_rejected, .seq_fault_flag, .valid_count, .sensor_message_ok,
  .sequence_mismatch, .sample_data_ok, .cmp_seq, .cmp_threshold, .cmp_dwell_long);
`default_nettype wire

// ===== bench/ssm_spi_peer.sv
// spi far side: host clocking frames out of a sensor receiver
`timescale 1ns/100ps
`default_nettype none
module ssm_spi_peer (
  output logic spi_sck,
  output logic spi_so,
  output logic [3:0] spi_cs_n
);
  // idle link: clock still, selects high
  initial begin
    spi_sck = 1'b0;
    spi_so = 1'b1;
    spi_cs_n = 4'hF;
  end
  // one frame of n edges at 400 ns, msb first
  task frame(input logic [15:0] w, input int n, input logic [3:0] cs);
    int i;
    spi_cs_n = cs;
    #400;
    for (i = 0; i < n; i++) begin
      spi_so = (i < 16) ? w[15 - i] : ~spi_so;
      #200;
      spi_sck = 1'b1;
      #200;
      spi_sck = 1'b0;
    end
    #200;
    spi_cs_n = 4'hF;
    // released line flips so no stale bit looks valid
    spi_so = ~spi_so;
    #800;
  endtask : frame
endmodule : ssm_spi_peer
`default_nettype wire

// ===== bench/ssm_monitor_tb_top.sv
// testbench: frame checks, sequence, data validation and thresholds
`timescale 1ns/100ps
`default_nettype none
module ssm_monitor_tb_top;
  typedef struct {logic [15:0] w; logic [4:0] n; logic [3:0] cs; logic [2:0] e;} ssm_row_t;
  logic sys_clk, reset, spi_sck, spi_so, sat_sync, cmd_valid, seen_dw;
  logic [3:0] spi_cs_n, valid_count, cmp_seq, seq_exp, seen_seq;
  ssm_pkg::ssm_mode_t ssm_mode;
  ssm_pkg::ssm_cmd_t cmd_kind;
  logic [2:0] cmd_thr_idx, thr_rd_idx, seen;
  logic [7:0] cmd_data, thr_rd_data;
  logic thr_write_done, thr_write_rejected, seq_fault_flag, sensor_message_ok;
  logic sequence_mismatch, sample_data_ok, cmp_dwell_long, sample_data_ok_sig, cmp_enable;
  logic [1:0] seen_ok;
  logic [9:0] cmp_sample, seen_smp;
  logic [8:0] cmp_threshold, seen_thr;
  int error_cnt = 0, samples_checked = 0, k;
  logic [7:0] thr_exp [8] = '{8'h0D, 8'h95, 8'h08, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04};
  // rows: word, edges, selects, {message, mismatch, data ok}
  ssm_row_t rows [18] = '{'{16'h41FF, 5'h10, 4'hE, 3'h5}, '{16'h4A00, 5'h14, 4'hD, 3'h5},
    '{16'h4000, 5'h0F, 4'hE, 3'h0}, '{16'h4000, 5'h10, 4'hC, 3'h0},
    '{16'h51E1, 5'h10, 4'hB, 3'h5}, '{16'h59E1, 5'h10, 4'hE, 3'h4},
    '{16'h61E0, 5'h10, 4'hE, 3'h5}, '{16'h6A20, 5'h10, 4'hE, 3'h5},
    '{16'hB000, 5'h10, 4'hE, 3'h4}, '{16'h7A1F, 5'h10, 4'hE, 3'h4},
    '{16'h4000, 5'h10, 4'hE, 3'h5}, '{16'h5000, 5'h10, 4'hE, 3'h6},
    '{16'h5000, 5'h10, 4'hE, 3'h4}, '{16'h5800, 5'h10, 4'hE, 3'h4},
    '{16'h6000, 5'h10, 4'hE, 3'h4}, '{16'h6800, 5'h10, 4'hE, 3'h4},
    '{16'h7000, 5'h10, 4'hE, 3'h4}, '{16'h7800, 5'h10, 4'hE, 3'h0}};
  ssm_spi_peer peer (.spi_sck, .spi_so, .spi_cs_n);
  ssm_monitor dut (.sys_clk, .reset, .spi_sck, .spi_so, .spi_cs_n, .sat_sync, .ssm_mode,
    .cmd_valid, .cmd_kind, .cmd_thr_idx, .cmd_data, .thr_write_done, .thr_write_rejected,
    .thr_rd_idx, .thr_rd_data, .seq_fault_flag, .valid_count, .sensor_message_ok,
    .sequence_mismatch, .sample_data_ok, .sample_data_ok_sig, .cmp_seq, .cmp_sample,
    .cmp_threshold, .cmp_dwell_long, .cmp_enable);
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // keep what the one-cycle message pulse carried; mid-cycle, away from the launching edge
  always @(negedge sys_clk) begin
    if (sensor_message_ok === 1'b1) begin
      seen = {1'b1, sequence_mismatch, sample_data_ok};
      seen_ok = {sample_data_ok_sig, cmp_enable};
      seen_smp = cmp_sample;
      seen_seq = cmp_seq;
      seen_thr = cmp_threshold;
      seen_dw = cmp_dwell_long;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // valid held across calls so back-to-back commands stay adjacent
  task cmd(input ssm_pkg::ssm_cmd_t kd, input int i, input logic [7:0] d, input logic [1:0] e);
    cmd_valid = 1'b1;
    cmd_kind = kd;
    cmd_thr_idx = i[2:0];
    cmd_data = d;
    @(posedge sys_clk) #1;
    chk({thr_write_done, thr_write_rejected}, e);
  endtask : cmd
  task rd(input int i);
    thr_rd_idx = i[2:0];
    repeat (2) @(posedge sys_clk);
    #1 chk(thr_rd_data, thr_exp[i]);
  endtask : rd
  task sync;
    sat_sync = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 sat_sync = 1'b0;
    seq_exp = 4'hF;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : sync
  task frm(input ssm_row_t r);
    seen = 3'h0;
    peer.frame(r.w, r.n, r.cs);
    if (r.e[2]) seq_exp++;
    chk(seen, r.e);
    if (r.e[2]) begin
      chk(seen_seq, seq_exp);
      chk(seen_ok, {2{r.e[0]}});
      chk(seen_smp, r.w[ssm_pkg::SAMPLE_MSB:ssm_pkg::SAMPLE_LSB]);
      chk({seen_dw, seen_thr}, {thr_exp[seq_exp[3:1]][7], 1'b0, thr_exp[seq_exp[3:1]]});
    end
  endtask : frm
  // main sequence
  initial begin
    reset = 1'b1;
    sat_sync = 1'b0;
    ssm_mode = ssm_pkg::SSM_STARTUP;
    cmd_valid = 1'b0;
    cmd_kind = ssm_pkg::SSM_CMD_OTHER;
    cmd_thr_idx = 3'h0;
    cmd_data = 8'h00;
    thr_rd_idx = 3'h0;
    seq_exp = 4'hF;
    repeat (20) @(posedge sys_clk);
    #1 reset = 1'b0;
    for (k = 0; k < 8; k++) rd(k);
    chk({seq_fault_flag, valid_count}, 5'h00);
    $display("reset values done");
    cmd(ssm_pkg::SSM_CMD_UNLOCK, 3, 8'h5A ^ 8'hAD, 2'h0);
    cmd(ssm_pkg::SSM_CMD_THR_WRITE, 3, 8'h5A, 2'h2);
    cmd(ssm_pkg::SSM_CMD_UNLOCK, 5, 8'h11 ^ 8'hAD, 2'h0);
    cmd(ssm_pkg::SSM_CMD_OTHER, 5, 8'h00, 2'h0);
    cmd(ssm_pkg::SSM_CMD_THR_WRITE, 5, 8'h11, 2'h1);
    cmd(ssm_pkg::SSM_CMD_UNLOCK, 6, 8'h22 ^ 8'hAD, 2'h0);
    cmd(ssm_pkg::SSM_CMD_THR_WRITE, 6, 8'h23, 2'h1);
    cmd(ssm_pkg::SSM_CMD_THR_WRITE, 7, 8'h80, 2'h1);
    ssm_mode = ssm_pkg::SSM_SCRAP;
    cmd(ssm_pkg::SSM_CMD_UNLOCK, 0, 8'h33 ^ 8'hAD, 2'h0);
    cmd(ssm_pkg::SSM_CMD_THR_WRITE, 0, 8'h33, 2'h1);
    cmd_valid = 1'b0;
    thr_exp[3] = 8'h5A;
    for (k = 0; k < 8; k++) rd(k);
    $display("threshold writes done");
    ssm_mode = ssm_pkg::SSM_SAFING;
    sync;
    foreach (rows[i]) frm(rows[i]);
    chk({seq_fault_flag, valid_count}, 5'h16);
    $display("frame table done");
    sync;
    chk({seq_fault_flag, valid_count}, 5'h00);
    frm(rows[0]);
    chk(valid_count, 4'h1);
    cmd(ssm_pkg::SSM_CMD_UNLOCK, 1, 8'h44 ^ 8'hAD, 2'h0);
    cmd(ssm_pkg::SSM_CMD_THR_WRITE, 1, 8'h44, 2'h1);
    cmd_valid = 1'b0;
    rd(1);
    ssm_mode = ssm_pkg::SSM_STARTUP;
    frm('{16'h4800, 5'h10, 4'hE, 3'h0});
    $display("mode and sync tests done");
    // mid-run reset: thresholds and counters back to defaults
    reset = 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 reset = 1'b0;
    thr_exp[3] = 8'h08;
    for (k = 0; k < 8; k++) rd(k);
    chk({seq_fault_flag, valid_count}, 5'h00);
    $display("mid-run reset done");
    end_sim;
  end
endmodule : ssm_monitor_tb_top
`default_nettype wire
